// ---- ic_bus_model.sv ----
// Purpose: Two-wire bus with pull-ups and an acknowledging slave
// Assumes: Lines resolved as wired-AND of all pull-downs
// Notes: Bench pulls lines through i_m_* to act as a master
`timescale 1ns/1ps
module ic_bus_model (
  input wire i_clock,
  input wire i_scl_oe_n,
  input wire i_sda_oe_n,
  input wire i_m_scl_low,
  input wire i_m_sda_low,
  input wire i_ack_en,
  output wire o_scl,
  output wire o_sda
);
  // ****************************************
  // Lines and responder
  // ****************************************
  reg [3:0] rises = 4'h0;
  reg ack_low = 1'b0;
  reg scl_d = 1'b1;
  reg sda_d = 1'b1;
  assign o_scl = i_scl_oe_n & ~i_m_scl_low;
  assign o_sda = i_sda_oe_n & ~i_m_sda_low & ~ack_low;
  always @(posedge i_clock) begin
    scl_d <= o_scl;
    sda_d <= o_sda;
    if (scl_d && o_scl && sda_d && !o_sda) begin
      rises <= 4'h0;
    end else if (!scl_d && o_scl) begin
      rises <= rises + 4'h1;
    end
    // Ack during ninth clock only
    if (scl_d && !o_scl) begin
      ack_low <= i_ack_en && rises == 4'h8;
    end
  end
endmodule // ic_bus_model

// ---- ic_byte_engine.v ----
// Purpose: Data buffer, own address match and bit rate of a two-wire controller
// Assumes: Bus pins and register port synchronous to i_clock
// Notes: Open-drain pins, enable low pulls the line low
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`include "ic_defs.vh"
module ic_byte_engine (
  input wire i_clock,
  input wire i_rst_n,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire i_scl,
  input wire i_sda,
  output reg o_scl_out,
  output reg o_scl_oe_n,
  output reg o_sda_out,
  output reg o_sda_oe_n,
  output reg o_serial_event,
  output reg o_ack_assert
);
  localparam ST_IDLE = 3'h0;
  localparam ST_MSTART = 3'h1;
  localparam ST_MBYTE = 3'h2;
  localparam ST_MSTOP = 3'h3;
  localparam ST_SBYTE = 3'h4;
  localparam ST_WAIT = 3'h5;

  reg [2:0] state;
  reg [7:0] byte_buf;
  reg [7:0] divider;
  reg [7:0] own_addr;
  reg master_enable;
  reg start_req;
  reg stop_req;
  reg master_rx;
  reg addressed;
  reg gcall_hit;
  reg arb_lost;
  reg ack_seen;
  reg slave_tx;
  reg bus_busy;
  reg as_master;
  reg addr_phase;
  reg [3:0] bit_cnt;
  reg scl_q;
  reg sda_q;
  wire tick;
  wire [1:0] phase;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  wire gen_run;
  wire gen_hold;
  wire own_match;
  wire gcall_match;
  wire [7:0] ctrl_val;
  wire [7:0] stat_val;

  function reg_hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      reg_hit = (addr == offset);
    end
  endfunction

  // ****************************************
  // Line edges and bus conditions
  // ****************************************
  assign scl_rise = i_scl & ~scl_q;
  assign scl_fall = ~i_scl & scl_q;
  assign start_det = scl_q & i_scl & sda_q & ~i_sda;
  assign stop_det = scl_q & i_scl & ~sda_q & i_sda;
  assign own_match = (byte_buf[7:1] == own_addr[7:1]) && (byte_buf[7:1] != 7'h00)
                     && o_ack_assert;
  assign gcall_match = (byte_buf[7:1] == 7'h00) && own_addr[`IC_ADDR_GC]
                       && o_ack_assert;
  assign gen_run = (state == ST_MSTART) || (state == ST_MBYTE) || (state == ST_MSTOP);
  // Another device stretching the clock freezes the quarter count
  assign gen_hold = o_scl_oe_n & ~i_scl & phase[1];
  assign ctrl_val = {2'h0, master_rx, stop_req, o_serial_event, o_ack_assert, start_req,
                     master_enable};
  assign stat_val = {1'b0, as_master, bus_busy, slave_tx, ack_seen, arb_lost, gcall_hit,
                     addressed};

  ic_rate_gen u_rate (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_run(gen_run),
    .i_hold(gen_hold),
    .i_divider(divider),
    .o_tick(tick),
    .o_phase(phase)
  );

  // ****************************************
  // Register read port
  // ****************************************
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= reg_hit(i_addr, `IC_OFF_BUF) ? byte_buf :
                 reg_hit(i_addr, `IC_OFF_DIV) ? divider :
                 reg_hit(i_addr, `IC_OFF_ADDR) ? own_addr :
                 reg_hit(i_addr, `IC_OFF_CTRL) ? ctrl_val :
                 reg_hit(i_addr, `IC_OFF_STAT) ? stat_val : 8'h00;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ****************************************
  // Byte engine and register writes
  // ****************************************
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      byte_buf <= `IC_RST_BUF;
      divider <= `IC_RST_DIV;
      own_addr <= `IC_RST_ADDR;
      master_enable <= 1'b0;
      start_req <= 1'b0;
      stop_req <= 1'b0;
      master_rx <= 1'b0;
      o_ack_assert <= 1'b0;
      o_serial_event <= 1'b0;
      addressed <= 1'b0;
      gcall_hit <= 1'b0;
      arb_lost <= 1'b0;
      ack_seen <= 1'b0;
      slave_tx <= 1'b0;
      bus_busy <= 1'b0;
      as_master <= 1'b0;
      addr_phase <= 1'b0;
      bit_cnt <= 4'h0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
      o_scl_oe_n <= 1'b1;
      o_sda_oe_n <= 1'b1;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
      if (start_det) begin
        bus_busy <= 1'b1;
      end else if (stop_det) begin
        bus_busy <= 1'b0;
      end
      if (i_wr && reg_hit(i_addr, `IC_OFF_BUF)) begin
        byte_buf <= i_wdata;
      end
      if (i_wr && reg_hit(i_addr, `IC_OFF_DIV)) begin
        divider <= i_wdata;
      end
      if (i_wr && reg_hit(i_addr, `IC_OFF_ADDR)) begin
        own_addr <= i_wdata;
      end
      if (i_wr && reg_hit(i_addr, `IC_OFF_CTRL)) begin
        master_enable <= i_wdata[`IC_CTRL_MASTER];
        start_req <= i_wdata[`IC_CTRL_START];
        stop_req <= i_wdata[`IC_CTRL_STOP];
        master_rx <= i_wdata[`IC_CTRL_MRX];
        o_ack_assert <= i_wdata[`IC_CTRL_ACK];
      end
      // Software clear; a set later in this block wins
      if (i_wr && reg_hit(i_addr, `IC_OFF_CTRL) && !i_wdata[`IC_CTRL_EVENT]) begin
        o_serial_event <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          o_scl_oe_n <= 1'b1;
          o_sda_oe_n <= 1'b1;
          if (master_enable && start_req && !bus_busy && !o_serial_event) begin
            state <= ST_MSTART;
            as_master <= 1'b1;
            arb_lost <= 1'b0;
          end else if (start_det && !o_serial_event && !master_enable) begin
            state <= ST_SBYTE;
            addr_phase <= 1'b1;
            bit_cnt <= 4'h0;
          end
        end
        ST_MSTART: begin
          if (tick) begin
            case (phase)
              2'h0: o_sda_oe_n <= 1'b1;
              2'h1: o_scl_oe_n <= 1'b1;
              2'h2: o_sda_oe_n <= 1'b0;
              default: begin
                o_scl_oe_n <= 1'b0;
                start_req <= 1'b0;
                addr_phase <= 1'b1;
                o_serial_event <= 1'b1;
                state <= ST_WAIT;
              end
            endcase
          end
        end
        ST_MBYTE: begin
          if (tick) begin
            case (phase)
              2'h0: begin
                o_scl_oe_n <= 1'b0;
                if (bit_cnt < `IC_BITS_PER_BYTE) begin
                  o_sda_oe_n <= master_rx | byte_buf[7];
                end else if (bit_cnt == `IC_BITS_PER_BYTE) begin
                  o_sda_oe_n <= master_rx ? ~o_ack_assert : 1'b1;
                end else begin
                  o_sda_oe_n <= 1'b1;
                  addr_phase <= 1'b0;
                  o_serial_event <= 1'b1;
                  state <= ST_WAIT;
                end
              end
              2'h2: o_scl_oe_n <= 1'b1;
              2'h3: begin
                bit_cnt <= bit_cnt + 4'h1;
                if (bit_cnt < `IC_BITS_PER_BYTE) begin
                  byte_buf <= {byte_buf[6:0], i_sda};
                  if (!master_rx && byte_buf[7] && !i_sda) begin
                    // Lost: finish the byte as a listening slave
                    arb_lost <= 1'b1;
                    as_master <= 1'b0;
                    o_sda_oe_n <= 1'b1;
                    state <= ST_SBYTE;
                  end
                end else begin
                  ack_seen <= ~i_sda;
                end
              end
              default: o_scl_oe_n <= o_scl_oe_n;
            endcase
          end
        end
        ST_MSTOP: begin
          if (tick) begin
            case (phase)
              2'h0: begin
                o_scl_oe_n <= 1'b0;
                o_sda_oe_n <= 1'b0;
              end
              2'h2: o_scl_oe_n <= 1'b1;
              2'h3: begin
                o_sda_oe_n <= 1'b1;
                stop_req <= 1'b0;
                as_master <= 1'b0;
                state <= ST_IDLE;
              end
              default: o_sda_oe_n <= 1'b0;
            endcase
          end
        end
        ST_SBYTE: begin
          if (stop_det) begin
            addressed <= 1'b0;
            o_sda_oe_n <= 1'b1;
            state <= ST_IDLE;
          end else if (start_det) begin
            addressed <= 1'b0;
            addr_phase <= 1'b1;
            bit_cnt <= 4'h0;
            o_sda_oe_n <= 1'b1;
          end else if (scl_rise) begin
            // Slave ignores the divider and follows the master clock
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt < `IC_BITS_PER_BYTE) begin
              byte_buf <= {byte_buf[6:0], i_sda};
            end else begin
              ack_seen <= ~i_sda;
            end
          end else if (scl_fall) begin
            if (bit_cnt < `IC_BITS_PER_BYTE) begin
              o_sda_oe_n <= slave_tx ? byte_buf[7] : 1'b1;
            end else if (bit_cnt == `IC_BITS_PER_BYTE) begin
              if (addr_phase) begin
                if (own_match || gcall_match) begin
                  o_sda_oe_n <= 1'b0;
                  addressed <= 1'b1;
                  gcall_hit <= ~own_match;
                  slave_tx <= own_match & byte_buf[0];
                end else begin
                  o_sda_oe_n <= 1'b1;
                  state <= ST_IDLE;
                end
              end else if (!slave_tx) begin
                o_sda_oe_n <= ~o_ack_assert;
                addressed <= o_ack_assert;
              end else begin
                o_sda_oe_n <= 1'b1;
              end
            end else begin
              o_sda_oe_n <= 1'b1;
              o_scl_oe_n <= 1'b0;
              addr_phase <= 1'b0;
              if (slave_tx && !ack_seen) begin
                addressed <= 1'b0;
              end
              o_serial_event <= 1'b1;
              state <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          // Clock held low keeps the buffer still for software
          if (!o_serial_event) begin
            bit_cnt <= 4'h0;
            if (as_master) begin
              if (stop_req) begin
                state <= ST_MSTOP;
              end else if (start_req) begin
                state <= ST_MSTART;
              end else begin
                state <= ST_MBYTE;
              end
            end else begin
              o_scl_oe_n <= 1'b1;
              if (addressed) begin
                o_sda_oe_n <= slave_tx ? byte_buf[7] : 1'b1;
                state <= ST_SBYTE;
              end else begin
                o_sda_oe_n <= 1'b1;
                slave_tx <= 1'b0;
                state <= ST_IDLE;
              end
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // ic_byte_engine

// ---- ic_byte_engine_props.sv ----
// Purpose: Port checker for the byte engine
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every engine instance
`timescale 1ns/1ps
module ic_byte_engine_props (
  input wire i_clock,
  input wire i_rst_n,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire i_scl,
  input wire i_sda,
  input wire o_scl_out,
  input wire o_scl_oe_n,
  input wire o_sda_out,
  input wire o_sda_oe_n,
  input wire o_serial_event,
  input wire o_ack_assert
);
  // ****************************************
  // Properties
  // ****************************************
  wire ctrl_wr = i_wr && i_addr == 8'hc0;
  wire ack_bit = i_wdata[2];
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_wr_div;
    i_wr && i_addr == 8'hbe;
  endsequence
  sequence s_rd_div;
    i_rd && i_addr == 8'hbe;
  endsequence
  property p_div_echo;
    s_wr_div ##1 s_rd_div |=> o_rdata == $past(i_wdata, 2);
  endproperty
  a_div_echo: assert property (p_div_echo) else $error("divider readback wrong");
  property p_rd_idle;
    !i_rd |=> o_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
  property p_unmapped;
    i_rd && i_addr == 8'hc3 |=> o_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_reset_out;
    $rose(i_rst_n) |-> o_scl_oe_n && o_sda_oe_n && !o_serial_event && !o_ack_assert;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs wrong after reset");
  property p_drive_low;
    o_scl_out == 1'b0 && o_sda_out == 1'b0;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("pin drive value not low");
  property p_event_stays;
    o_serial_event && !ctrl_wr |=> o_serial_event;
  endproperty
  a_event_stays: assert property (p_event_stays) else $error("event dropped alone");
  property p_event_hold;
    $rose(o_serial_event) |=> !o_scl_oe_n [*2];
  endproperty
  a_event_hold: assert property (p_event_hold) else $error("clock not held at event");
  property p_ack_set;
    ctrl_wr |=> o_ack_assert == $past(ack_bit);
  endproperty
  a_ack_set: assert property (p_ack_set) else $error("ack flag not written");
  property p_ack_stable;
    !ctrl_wr |=> $stable(o_ack_assert);
  endproperty
  a_ack_stable: assert property (p_ack_stable) else $error("ack flag changed alone");
endmodule // ic_byte_engine_props

bind ic_byte_engine ic_byte_engine_props u_props (.i_clock(i_clock), .i_rst_n(i_rst_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_scl(i_scl), .i_sda(i_sda), .o_scl_out(o_scl_out), .o_scl_oe_n(o_scl_oe_n),
  .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .o_serial_event(o_serial_event),
  .o_ack_assert(o_ack_assert));

// ---- ic_byte_engine_test.sv ----
// Purpose: Self-checking bench for the byte engine
// Assumes: Bus model resolves both lines
// Notes: Divider 2 gives a 12-clock master bit
`timescale 1ns/1ps
module ic_byte_engine_test;
  // ****************************************
  // Harness
  // ****************************************
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg wr = 1'b0, rd = 1'b0, m_scl = 1'b0, m_sda = 1'b0, ack_en = 1'b0, s_bit = 1'b1;
  reg [7:0] addr = 8'h00, wdata = 8'h00, got = 8'h00;
  reg [8:0] rx = 9'h000;
  reg scl_q = 1'b1;
  reg [31:0] tab [0:5];
  wire [7:0] rdata;
  wire scl, sda, scl_oe_n, sda_oe_n, ev, ack_f;
  integer miscompares = 0, checks_done = 0, cyc = 0, last = 0, period = 0, n, j, k;
  ic_bus_model bus (.i_clock(clock), .i_scl_oe_n(scl_oe_n), .i_sda_oe_n(sda_oe_n),
    .i_m_scl_low(m_scl), .i_m_sda_low(m_sda), .i_ack_en(ack_en), .o_scl(scl), .o_sda(sda));
  ic_byte_engine dut (.i_clock(clock), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_scl(scl), .i_sda(sda), .o_scl_out(),
    .o_scl_oe_n(scl_oe_n), .o_sda_out(), .o_sda_oe_n(sda_oe_n), .o_serial_event(ev),
    .o_ack_assert(ack_f));
  initial begin
    forever #12.5 clock = ~clock;
  end
  // Wire monitor: bits at clock rise, bit period
  always @(negedge clock) begin
    cyc <= cyc + 1;
    scl_q <= scl;
    if (!scl_q && scl) begin
      rx <= {rx[7:0], sda};
      period <= cyc - last;
      last <= cyc;
    end
  end
  task wrap_up;
    begin
      if (miscompares == 0 && checks_done > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  task chk(input [63:0] what, input [7:0] exp, input [7:0] seen);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("mismatch %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // ****************************************
  // Bus and line tasks
  // ****************************************
  task rst;
    begin
      rst_n <= 1'b0;
      ack_en <= 1'b0;
      m_scl <= 1'b0;
      m_sda <= 1'b0;
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
    end
  endtask
  task wreg(input [7:0] a, input [7:0] d);
    begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      @(posedge clock);
    end
  endtask
  task rreg(input [7:0] a);
    begin
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      got = rdata;
      @(posedge clock);
    end
  endtask
  task wrd(input [7:0] a, input [7:0] d);
    begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      got = rdata;
      @(posedge clock);
    end
  endtask
  task wait_ev;
    begin
      n = 0;
      @(negedge clock);
      while (ev !== 1'b1 && n < 2000) begin
        @(negedge clock);
        n = n + 1;
      end
      chk("event", 8'h01, {7'h00, ev});
      @(posedge clock);
    end
  endtask
  task ext_bit(input b);
    begin
      m_sda <= ~b;
      repeat (10) @(posedge clock);
      m_scl <= 1'b0;
      repeat (10) @(negedge clock);
      s_bit = sda;
      @(posedge clock);
      m_scl <= 1'b1;
      repeat (10) @(posedge clock);
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_regs;
    begin
      rst;
      rreg(8'hbc);
      chk("buf", 8'h00, got);
      rreg(8'hbe);
      chk("div", 8'h09, got);
      rreg(8'hc1);
      chk("own", 8'h00, got);
      wreg(8'hc3, 8'h5a);
      rreg(8'hc3);
      chk("unmap", 8'h00, got);
      wreg(8'hc1, 8'ha1);
      rreg(8'hc1);
      chk("own", 8'ha1, got);
      wrd(8'hbe, 8'h02);
      chk("div", 8'h02, got);
    end
  endtask
  task t_master;
    begin
      rst;
      wreg(8'hbe, 8'h02);
      wreg(8'hc0, 8'h07);
      wait_ev;
      chk("sda", 8'h00, {7'h00, sda});
      chk("ackflag", 8'h01, {7'h00, ack_f});
      wreg(8'hbc, 8'ha5);
      ack_en <= 1'b1;
      wreg(8'hc0, 8'h05);
      wait_ev;
      chk("wire", 8'ha5, rx[8:1]);
      chk("period", 8'h0c, period[7:0]);
      chk("ackbit", 8'h00, {7'h00, rx[0]});
      rreg(8'hc2);
      chk("ackseen", 8'h08, got & 8'h08);
      repeat (40) @(posedge clock);
      rreg(8'hbc);
      chk("buf", 8'ha5, got);
      wreg(8'hc0, 8'h15);
      repeat (60) @(posedge clock);
      chk("idle", 8'h03, {6'h00, scl, sda});
    end
  endtask
  task t_slave;
    begin
      tab[0] = 32'ha0_04_a0_01;
      tab[1] = 32'ha0_00_a0_00;
      tab[2] = 32'ha1_04_00_01;
      tab[3] = 32'ha0_04_00_00;
      tab[4] = 32'ha1_00_00_00;
      tab[5] = 32'ha0_04_a2_00;
      for (k = 0; k < 6; k = k + 1) begin
        rst;
        wreg(8'hbe, 8'h02);
        wreg(8'hc1, tab[k][31:24]);
        wreg(8'hc0, tab[k][23:16]);
        m_sda <= 1'b1;
        repeat (10) @(posedge clock);
        m_scl <= 1'b1;
        for (j = 0; j < 9; j = j + 1) begin
          ext_bit(j == 8 ? 1'b1 : tab[k][15 - j]);
        end
        chk("ack", {7'h00, ~tab[k][0]}, {7'h00, s_bit});
        repeat (10) @(posedge clock);
        chk("event", tab[k][7:0], {7'h00, ev});
        if (tab[k][0]) begin
          m_scl <= 1'b0;
          repeat (4) @(posedge clock);
          chk("hold", 8'h00, {7'h00, scl});
          rreg(8'hbc);
          chk("buf", tab[k][15:8], got);
        end
      end
    end
  endtask
  initial begin
    t_regs;
    t_master;
    t_slave;
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge clock);
    miscompares = miscompares + 1;
    wrap_up;
  end
endmodule // ic_byte_engine_test

// ---- ic_defs.vh ----
// Purpose: Shared constants for the two-wire data, address and rate block
// Assumes: Plain Verilog-2005, included by bare name
// Notes: Offsets are 8-bit register port addresses
`ifndef IC_DEFS_VH
`define IC_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define IC_OFF_BUF 8'hbc
`define IC_OFF_DIV 8'hbe
`define IC_OFF_CTRL 8'hc0
`define IC_OFF_ADDR 8'hc1
`define IC_OFF_STAT 8'hc2

// ****************************************
// Reset values
// ****************************************
`define IC_RST_BUF 8'h00
`define IC_RST_DIV 8'h09
`define IC_RST_ADDR 8'h00

// ****************************************
// Control field positions
// ****************************************
`define IC_CTRL_MASTER 0
`define IC_CTRL_START 1
`define IC_CTRL_ACK 2
`define IC_CTRL_EVENT 3
`define IC_CTRL_STOP 4
`define IC_CTRL_MRX 5

// ****************************************
// Status field positions
// ****************************************
`define IC_STAT_ADDRESSED 0
`define IC_STAT_GCALL 1
`define IC_STAT_ARBLOST 2
`define IC_STAT_ACKSEEN 3
`define IC_STAT_STX 4
`define IC_STAT_BUSY 5
`define IC_STAT_ASMASTER 6

// ****************************************
// Own address fields and timing
// ****************************************
`define IC_ADDR_GC 0
`define IC_BITS_PER_BYTE 4'h8
`define IC_SYS_CLOCK_HZ 40000000
`define IC_SLAVE_MAX_BPS 400000

`endif

// ---- ic_rate_gen.v ----
// Purpose: Quarter-period tick generator for master serial clock
// Assumes: Divider value of 2 or more
// Notes: One bit time is four quarters of divider plus one clocks
`timescale 1ns/1ps
module ic_rate_gen (
  input wire i_clock,
  input wire i_rst_n,
  input wire i_run,
  input wire i_hold,
  input wire [7:0] i_divider,
  output reg o_tick,
  output reg [1:0] o_phase
);
  reg [7:0] count;

  // ****************************************
  // Quarter counter
  // ****************************************
  always @(posedge i_clock) begin
    if (!i_rst_n || !i_run) begin
      count <= 8'h00;
      o_tick <= 1'b0;
      o_phase <= 2'h3;
    end else if (i_hold) begin
      o_tick <= 1'b0;
    end else if (count == i_divider) begin
      count <= 8'h00;
      o_tick <= 1'b1;
      o_phase <= o_phase + 2'h1;
    end else begin
      count <= count + 8'h01;
      o_tick <= 1'b0;
    end
  end
endmodule // ic_rate_gen
